// ---- rtl/serial_status_flags.sv ----
// Purpose: Status flags, error stall and multiprocessor bits of a serial channel
// Assumes: External shifters report completed characters as one-cycle pulses
// Notes:   Registers answer over APB with one wait state
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/100ps

module serial_status_flags
	import serial_status_pkg::*;
#(
	parameter int CHAR_W = 8
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              low_power_init,
	input  wire logic              rx_done,
	input  wire logic [CHAR_W-1:0] rx_char,
	input  wire logic              rx_parity_bit,
	input  wire logic              rx_stop_bit,
	input  wire logic              rx_mpb_in,
	input  wire logic              dtc_rx_read,
	input  wire logic              dtc_tx_write,
	input  wire logic [CHAR_W-1:0] dtc_tx_data,
	input  wire logic              tx_load,
	input  wire logic              tx_last_bit,
	output logic                   rx_hold,
	output logic                   tx_hold,
	output logic                   tx_mpb_out,
	output logic      [CHAR_W-1:0] tx_char,
	output logic                   tx_data_empty,
	output logic                   tx_end
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [7:0]        sts;
		logic [7:0]        seen;
		logic [7:0]        ctrl;
		logic [CHAR_W-1:0] rx_data_reg;
		logic [CHAR_W-1:0] tx_data_reg;
		logic [31:0]       prdata;
		logic              pready;
		logic              pslverr;
		logic              rx_hold;
		logic              tx_hold;
		logic              tx_mpb;
	} state_s;

	state_s state_ff;
	state_s nxt_state;

	// Bus qualifiers
	logic              bus_prep;
	logic              bus_take;
	logic              wr_take;
	logic              rd_take;
	logic              mapped;
	logic              hit_status;
	logic              hit_control;
	logic              hit_rxdata;
	logic              hit_txdata;
	logic              status_wr;
	logic              control_wr;
	logic              txdata_wr;
	logic              status_rd;

	// Mode decode
	logic              rx_en;
	logic              tx_en;
	logic              sync_mode;
	logic              async_mode;
	logic              par_en;
	logic              par_odd;
	logic              multiproc;

	// Receive path
	logic              any_err;
	logic              rx_ok;
	logic              rx_over;
	logic              rx_store;
	logic              stop_bad;
	logic              par_calc;
	logic              par_bad;
	logic              rx_clean;
	logic              mpb_load;

	// Flag events
	logic [7:0]        read_word;
	logic [7:0]        sw_clr;
	logic [7:0]        arm;
	logic              tx_data_empty_flag_sw_clr;
	logic              tx_data_empty_flag_set;
	logic              tx_data_empty_flag_clr;
	logic              rx_data_full_flag_set;
	logic              rx_data_full_flag_clr;
	logic              overrun_error_flag_set;
	logic              fer_set;
	logic              per_set;
	logic              transmit_end_flag_set;
	logic              transmit_end_flag_clr;

	// ****************************************
	// Bus decode
	// ****************************************
	// One wait state gives prdata a flop of its own
	assign bus_prep    = psel && penable && !state_ff.pready;
	assign bus_take    = psel && penable && state_ff.pready;
	assign wr_take     = bus_take && pwrite && !state_ff.pslverr;
	assign rd_take     = bus_take && !pwrite && !state_ff.pslverr;
	assign hit_status  = (paddr == STATUS_OFS);
	assign hit_control = (paddr == CONTROL_OFS);
	assign hit_rxdata  = (paddr == RXDATA_OFS);
	assign hit_txdata  = (paddr == TXDATA_OFS);
	assign mapped      = hit_status || hit_control || hit_rxdata || hit_txdata;
	assign status_wr   = wr_take && hit_status;
	assign control_wr  = wr_take && hit_control;
	assign txdata_wr   = wr_take && hit_txdata;
	assign status_rd   = rd_take && hit_status;
	// Arm from the word that went out, not from flags that rose meanwhile
	assign read_word   = state_ff.prdata[7:0];

	// ****************************************
	// Mode decode
	// ****************************************
	assign rx_en      = state_ff.ctrl[CTL_RX_EN];
	assign tx_en      = state_ff.ctrl[CTL_TX_EN];
	assign sync_mode  = state_ff.ctrl[CTL_SYNC];
	assign async_mode = !sync_mode;
	assign par_en     = state_ff.ctrl[CTL_PAR_EN];
	assign par_odd    = state_ff.ctrl[CTL_PAR_ODD];
	assign multiproc  = state_ff.ctrl[CTL_MULTIPROC];

	// ****************************************
	// Receive checks
	// ****************************************
	assign any_err  = state_ff.sts[OVERRUN_ERROR_FLAG_BIT] ||
	                  state_ff.sts[FER_BIT] ||
	                  state_ff.sts[PER_BIT];
	// Receive enable low or an error pending both block the character
	assign rx_ok    = rx_done && rx_en && !any_err;
	assign rx_over  = rx_ok && state_ff.sts[RX_DATA_FULL_FLAG_BIT];
	assign rx_store = rx_ok && !state_ff.sts[RX_DATA_FULL_FLAG_BIT];
	// Shifter reports the first stop bit only, so a second one never counts
	assign stop_bad = async_mode && !rx_stop_bit;
	assign par_calc = ^{rx_char, rx_parity_bit};
	assign par_bad  = async_mode && par_en && (par_calc != par_odd);
	assign rx_clean = !stop_bad && !par_bad;
	assign mpb_load = rx_store && async_mode && multiproc;

	// ****************************************
	// Flag events
	// ****************************************
	// A clear needs a 0 in the write word and an earlier read of 1
	for (genvar g = 0; g < $bits(read_word); g++) begin : g_clr
		assign sw_clr[g] = status_wr && CLEARABLE[g] && !pwdata[g] &&
		                   state_ff.seen[g];
		assign arm[g]    = status_rd && CLEARABLE[g] && read_word[g];
	end

	assign tx_data_empty_flag_sw_clr = sw_clr[TX_DATA_EMPTY_FLAG_BIT];
	// Disabled transmitter forces both transmit flags high
	assign tx_data_empty_flag_set    = !tx_en || tx_load;
	assign tx_data_empty_flag_clr    = tx_data_empty_flag_sw_clr || dtc_tx_write;
	assign rx_data_full_flag_set    = rx_store && rx_clean;
	assign rx_data_full_flag_clr    = sw_clr[RX_DATA_FULL_FLAG_BIT] || dtc_rx_read;
	assign overrun_error_flag_set    = rx_over;
	assign fer_set     = rx_store && stop_bad;
	assign per_set     = rx_store && par_bad;
	// Transmit end follows the empty-flag clear; it has no write path
	assign transmit_end_flag_set    = !tx_en || (tx_last_bit && state_ff.sts[TX_DATA_EMPTY_FLAG_BIT]);
	assign transmit_end_flag_clr    = tx_data_empty_flag_clr;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		nxt_state = state_ff;

		// ****************************************
		// Bus answer
		// ****************************************
		nxt_state.pready  = bus_prep;
		nxt_state.pslverr = bus_prep && !mapped;
		nxt_state.prdata  = PRDATA_RST;
		if (bus_prep && !pwrite) begin
			case (paddr)
				STATUS_OFS: begin
					nxt_state.prdata[7:0] = state_ff.sts;
				end
				CONTROL_OFS: begin
					nxt_state.prdata[7:0] = state_ff.ctrl;
				end
				RXDATA_OFS: begin
					nxt_state.prdata[CHAR_W-1:0] = state_ff.rx_data_reg;
				end
				TXDATA_OFS: begin
					nxt_state.prdata[CHAR_W-1:0] = state_ff.tx_data_reg;
				end
				default: begin
					nxt_state.prdata = PRDATA_RST;
				end
			endcase
		end

		// Remember flags that software has seen at 1
		if (status_rd) begin
			nxt_state.seen = state_ff.seen | arm;
		end

		// ****************************************
		// Software writes
		// ****************************************
		if (status_wr) begin
			nxt_state.sts[TX_MULTIPROC_BIT_BIT] = pwdata[TX_MULTIPROC_BIT_BIT];
		end
		if (control_wr) begin
			nxt_state.ctrl = pwdata[7:0];
		end
		if (txdata_wr) begin
			nxt_state.tx_data_reg = pwdata[CHAR_W-1:0];
		end
		// Controller load shares the register with the bus write
		if (dtc_tx_write) begin
			nxt_state.tx_data_reg = dtc_tx_data;
		end

		// ****************************************
		// Flag clears
		// ****************************************
		for (int i = 0; i < $bits(read_word); i++) begin
			if (sw_clr[i]) begin
				nxt_state.sts[i]  = 1'b0;
				nxt_state.seen[i] = 1'b0;
			end
		end
		if (tx_data_empty_flag_clr) begin
			nxt_state.sts[TX_DATA_EMPTY_FLAG_BIT]  = 1'b0;
			nxt_state.seen[TX_DATA_EMPTY_FLAG_BIT] = 1'b0;
		end
		if (rx_data_full_flag_clr) begin
			nxt_state.sts[RX_DATA_FULL_FLAG_BIT]  = 1'b0;
			nxt_state.seen[RX_DATA_FULL_FLAG_BIT] = 1'b0;
		end
		if (transmit_end_flag_clr) begin
			nxt_state.sts[TRANSMIT_END_FLAG_BIT] = 1'b0;
		end

		// ****************************************
		// Flag sets, last so they beat any clear above
		// ****************************************
		if (tx_data_empty_flag_set) begin
			nxt_state.sts[TX_DATA_EMPTY_FLAG_BIT] = 1'b1;
		end
		if (transmit_end_flag_set) begin
			nxt_state.sts[TRANSMIT_END_FLAG_BIT] = 1'b1;
		end
		if (overrun_error_flag_set) begin
			nxt_state.sts[OVERRUN_ERROR_FLAG_BIT] = 1'b1;
		end
		if (fer_set) begin
			nxt_state.sts[FER_BIT] = 1'b1;
		end
		if (per_set) begin
			nxt_state.sts[PER_BIT] = 1'b1;
		end
		if (rx_data_full_flag_set) begin
			nxt_state.sts[RX_DATA_FULL_FLAG_BIT] = 1'b1;
		end

		// ****************************************
		// Receive store
		// ****************************************
		// Receive enable low blocks new characters only; old flags stay
		if (rx_store) begin
			nxt_state.rx_data_reg = rx_char;
		end
		if (mpb_load) begin
			nxt_state.sts[MPB_BIT] = rx_mpb_in;
		end

		// ****************************************
		// Stall and multiprocessor outputs
		// ****************************************
		// Built from the next flags so they move on the same edge
		nxt_state.rx_hold = nxt_state.sts[OVERRUN_ERROR_FLAG_BIT] ||
		                    nxt_state.sts[FER_BIT] ||
		                    nxt_state.sts[PER_BIT];
		nxt_state.tx_hold = nxt_state.ctrl[CTL_SYNC] &&
		                    nxt_state.rx_hold;
		nxt_state.tx_mpb  = nxt_state.sts[TX_MULTIPROC_BIT_BIT] &&
		                    nxt_state.ctrl[CTL_TX_EN] &&
		                    nxt_state.ctrl[CTL_MULTIPROC] &&
		                    !nxt_state.ctrl[CTL_SYNC];

		// ****************************************
		// Low power
		// ****************************************
		// Standby and module stop return the flags to their start values
		if (low_power_init) begin
			nxt_state.sts     = STATUS_RST;
			nxt_state.seen    = '0;
			nxt_state.rx_hold = 1'b0;
			nxt_state.tx_hold = 1'b0;
			nxt_state.tx_mpb  = 1'b0;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff         <= '0;
			state_ff.sts     <= STATUS_RST;
			state_ff.ctrl    <= CONTROL_RST;
			state_ff.prdata  <= PRDATA_RST;
			state_ff.seen    <= '0;
			state_ff.rx_data_reg     <= '0;
			state_ff.tx_data_reg     <= '0;
			state_ff.pready  <= 1'b0;
			state_ff.pslverr <= 1'b0;
			state_ff.rx_hold <= 1'b0;
			state_ff.tx_hold <= 1'b0;
			state_ff.tx_mpb  <= 1'b0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign prdata        = state_ff.prdata;
	assign pready        = state_ff.pready;
	assign pslverr       = state_ff.pslverr;
	assign rx_hold       = state_ff.rx_hold;
	assign tx_hold       = state_ff.tx_hold;
	assign tx_mpb_out    = state_ff.tx_mpb;
	assign tx_char       = state_ff.tx_data_reg;
	assign tx_data_empty = state_ff.sts[TX_DATA_EMPTY_FLAG_BIT];
	assign tx_end        = state_ff.sts[TRANSMIT_END_FLAG_BIT];

endmodule

// ---- rtl/serial_status_pkg.sv ----
// Purpose: Shared constants for the serial status flag block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Status layout keeps the classic eight-bit flag order
package serial_status_pkg;
	// ****************************************
	// Register byte addresses
	// ****************************************
	localparam logic [7:0]  STATUS_OFS    = 8'h00;
	localparam logic [7:0]  CONTROL_OFS   = 8'h04;
	localparam logic [7:0]  RXDATA_OFS    = 8'h08;
	localparam logic [7:0]  TXDATA_OFS    = 8'h0C;
	localparam int          ADDR_W        = 8;

	// ****************************************
	// Status field positions and reset
	// ****************************************
	localparam int          TX_DATA_EMPTY_FLAG_BIT      = 7;
	localparam int          RX_DATA_FULL_FLAG_BIT      = 6;
	localparam int          OVERRUN_ERROR_FLAG_BIT      = 5;
	localparam int          FER_BIT       = 4;
	localparam int          PER_BIT       = 3;
	localparam int          TRANSMIT_END_FLAG_BIT      = 2;
	localparam int          MPB_BIT       = 1;
	localparam int          TX_MULTIPROC_BIT_BIT      = 0;
	localparam logic [7:0]  STATUS_RST    = 8'h84;
	localparam logic [7:0]  CLEARABLE     = 8'hF8;

	// ****************************************
	// Control field positions and reset
	// ****************************************
	localparam int          CTL_RX_EN     = 0;
	localparam int          CTL_TX_EN     = 1;
	localparam int          CTL_SYNC      = 2;
	localparam int          CTL_PAR_EN    = 3;
	localparam int          CTL_PAR_ODD   = 4;
	localparam int          CTL_TWO_STOP  = 5;
	localparam int          CTL_MULTIPROC = 6;
	localparam logic [7:0]  CONTROL_RST   = 8'h00;
	localparam logic [31:0] PRDATA_RST    = 32'h0000_0000;
endpackage

// ---- sim/serial_peer.sv ----
// Purpose: Far-side shifter model for the serial status block
// Assumes: One-cycle pulses launched just after a rising edge
// Notes:   Data lines carry inverted junk when not qualified
`timescale 1ns/100ps
module serial_peer (
	input  wire logic       pclk,
	output logic            rx_done,
	output logic      [7:0] rx_char,
	output logic            rx_parity_bit,
	output logic            rx_stop_bit,
	output logic            rx_mpb_in,
	output logic            tx_load,
	output logic            tx_last_bit
);
	initial {rx_done, rx_char, rx_parity_bit, rx_stop_bit, rx_mpb_in, tx_load, tx_last_bit} = '0;
	// Only the first stop bit is handed over, the second never matters
	task automatic send(input logic [7:0] c, input logic p, s, m);
		@(posedge pclk);
		{rx_done, rx_char, rx_parity_bit, rx_stop_bit, rx_mpb_in} <= {1'b1, c, p, s, m};
		@(posedge pclk);
		{rx_done, rx_char, rx_parity_bit, rx_stop_bit, rx_mpb_in} <= {1'b0, ~c, ~p, ~s, ~m};
	endtask
	task automatic tx(input logic last);
		@(posedge pclk);
		{tx_load, tx_last_bit} <= {~last, last};
		@(posedge pclk);
		{tx_load, tx_last_bit} <= 2'h0;
	endtask
endmodule

// ---- sim/serial_status_sva.sv ----
// Purpose: Port checker for the serial status flag block
// Assumes: One APB wait state
// Notes:   Control bits are internal, so checks stay mode-free
`timescale 1ns/100ps
module serial_status_sva
	import serial_status_pkg::*;
(
	input wire logic              pclk, presetn, psel, penable, pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic              pready, pslverr, low_power_init, rx_done,
	input wire logic              tx_last_bit, rx_hold, tx_hold, tx_mpb_out,
	input wire logic              tx_data_empty, tx_end
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic apb_w;
	logic st_w;
	assign apb_w = psel && penable && pready && pwrite;
	assign st_w = apb_w && paddr == STATUS_OFS;
	ready_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("ready late");
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
	unmapped_err_a: assert property (psel && penable && pready && paddr > TXDATA_OFS |-> pslverr)
		else $error("no slave error");
	end_set_a: assert property (tx_last_bit && tx_data_empty |=> tx_end)
		else $error("end flag not set");
	sync_hold_a: assert property (tx_hold |-> rx_hold) else $error("tx stall alone");
	err_hold_a: assert property (rx_hold && !st_w && !low_power_init |=> rx_hold)
		else $error("error stall dropped");
	err_cause_a: assert property ($rose(rx_hold) |-> $past(rx_done))
		else $error("stall without char");
	tx_multiproc_bit_quiet_a: assert property (!$stable(tx_mpb_out) |-> $past(apb_w) || $past(low_power_init))
		else $error("mpb out moved");
	low_power_a: assert property (low_power_init |=> tx_data_empty && tx_end && !rx_hold)
		else $error("low power init");
endmodule
bind serial_status_flags serial_status_sva chk (.*);

// ---- sim/test_serial_status_flags.sv ----
// Purpose: Self-checking bench for the serial status flag block
// Assumes: Partner model drives the shifter side
// Notes:   Expected status words written as literal hex constants
`timescale 1ns/100ps
module test_serial_status_flags import serial_status_pkg::*;;
	localparam logic [7:0] ST = STATUS_OFS, CT = CONTROL_OFS, RX = RXDATA_OFS;
	logic pclk, presetn, psel, penable, pwrite, low_power_init, pready, pslverr, rerr;
	logic dtc_rx_read, dtc_tx_write, rx_done, rx_parity_bit, rx_stop_bit, rx_mpb_in;
	logic tx_load, tx_last_bit, rx_hold, tx_hold, tx_mpb_out, tx_data_empty, tx_end;
	logic [7:0]  paddr, rx_char, dtc_tx_data, tx_char;
	logic [31:0] pwdata, prdata, rdat;
	int          failures = 0, check_count = 0;
	serial_peer peer (.*);
	serial_status_flags dut (.*);
	always #12.5 pclk = ~pclk;
	task automatic chk(input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		{psel, penable} <= 2'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask
	task automatic pulse_in(input logic data_transfer_controller);
		@(posedge pclk);
		{dtc_tx_write, low_power_init, dtc_tx_data} <= {data_transfer_controller, ~data_transfer_controller, 8'hA5};
		@(posedge pclk);
		{dtc_tx_write, low_power_init, dtc_tx_data} <= {2'h0, 8'h5A};
	endtask
	task automatic t_reg();
		rd(ST, 32'h84);
		apb(1'b1, ST, 32'hFF);
		rd(ST, 32'h85);
		apb(1'b1, ST, 32'h84);
		rd(8'h10, 32'h0);
		chk(rerr, 1'b1);
	endtask
	task automatic t_over();
		apb(1'b1, CT, 32'h01);
		peer.send(8'h55, 1'b1, 1'b1, 1'b0);
		rd(ST, 32'hC4);
		peer.send(8'hAA, 1'b1, 1'b1, 1'b0);
		rd(ST, 32'hE4);
		#1 chk(rx_hold, 1'b1);
		peer.send(8'h33, 1'b1, 1'b1, 1'b0);
		rd(RX, 32'h55);
		apb(1'b1, CT, 32'h00);
		rd(ST, 32'hE4);
		apb(1'b1, ST, 32'h84);
		rd(ST, 32'h84);
	endtask
	task automatic t_frame();
		apb(1'b1, CT, 32'h01);
		peer.send(8'h12, 1'b0, 1'b0, 1'b0);
		apb(1'b1, ST, 32'h84);
		rd(ST, 32'h94);
		rd(RX, 32'h12);
		#1 chk(tx_hold, 1'b0);
		apb(1'b1, ST, 32'h84);
		rd(ST, 32'h84);
	endtask
	task automatic t_par();
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, CT, i ? 32'h19 : 32'h09);
			peer.send(8'h03, 1'b1, 1'b1, 1'b0);
			rd(ST, i ? 32'hC4 : 32'h8C);
			rd(RX, 32'h03);
			apb(1'b1, ST, 32'h84);
		end
	endtask
	task automatic t_sync();
		apb(1'b1, CT, 32'h07);
		peer.send(8'h21, 1'b0, 1'b0, 1'b0);
		peer.send(8'h22, 1'b0, 1'b0, 1'b0);
		rd(ST, 32'hE4);
		#1 chk(tx_hold, 1'b1);
		apb(1'b1, ST, 32'h84);
		apb(1'b1, CT, 32'h00);
	endtask
	task automatic t_tx();
		apb(1'b1, CT, 32'h42);
		apb(1'b1, ST, 32'h85);
		#1 chk(tx_mpb_out, 1'b1);
		apb(1'b1, CT, 32'h02);
		#1 chk(tx_mpb_out, 1'b0);
		pulse_in(1'b1);
		rd(ST, 32'h01);
		chk(tx_char, 8'hA5);
		peer.tx(1'b0);
		peer.tx(1'b1);
		rd(ST, 32'h85);
		apb(1'b1, ST, 32'h81);
		rd(ST, 32'h85);
		apb(1'b1, ST, 32'h05);
		rd(ST, 32'h01);
		apb(1'b1, CT, 32'h00);
		rd(ST, 32'h85);
		apb(1'b1, ST, 32'h84);
	endtask
	task automatic t_mpb();
		apb(1'b1, CT, 32'h41);
		peer.send(8'h5A, 1'b0, 1'b1, 1'b1);
		rd(ST, 32'hC6);
		apb(1'b1, ST, 32'hC4);
		apb(1'b1, CT, 32'h40);
		rd(ST, 32'hC6);
		@(posedge pclk) dtc_rx_read <= 1'b1;
		@(posedge pclk) dtc_rx_read <= 1'b0;
		rd(ST, 32'h86);
		pulse_in(1'b0);
		rd(ST, 32'h84);
	endtask
	task automatic stop_test();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		{pclk, presetn, psel, penable, pwrite, low_power_init, dtc_rx_read, dtc_tx_write} = '0;
		{paddr, pwdata, dtc_tx_data} = '0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reg();
		t_over();
		t_frame();
		t_par();
		t_sync();
		t_tx();
		t_mpb();
		stop_test();
	end
	initial begin
		#50us;
		failures++;
		stop_test();
	end
endmodule
